// file: common/gpc_defines.svh
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define GPC_OFF_ACTIVATE   8'h30
`define GPC_OFF_BASE_HI    8'h60
`define GPC_OFF_BASE_LO    8'h61
`define GPC_OFF_IRQ_NUM    8'h70
`define GPC_OFF_IRQ_TYPE   8'h71
`define GPC_OFF_DMA_0      8'h74
`define GPC_OFF_DMA_1      8'h75
`define GPC_OFF_PIN_SEL    8'hf0
`define GPC_OFF_PIN_CFG    8'hf1
`define GPC_OFF_ROUTE      8'hf2
`define GPC_OFF_CTRL       8'hf8

// ****************************************
// Reset and constant values
// ****************************************
`define GPC_RST_ZERO       8'h00
`define GPC_RST_IRQ_TYPE   8'h03
`define GPC_DMA_NONE       8'h04
`define GPC_RST_CFG_EVT    8'h44
`define GPC_RST_CFG_PLAIN  8'h04

// ****************************************
// Field positions and masks
// ****************************************
`define GPC_BIT_UNIT_EN    7
`define GPC_BASE_LO_MASK   8'hf0
`define GPC_IRQ_TYPE_WMASK 8'h02
`define GPC_SEL_MASK       8'h77
`define GPC_CFG_EVT_MASK   8'h7f
`define GPC_CFG_PLAIN_MASK 8'h0f
`define GPC_CFG_LOCKED_MASK 8'h0f
`define GPC_ROUTE_MASK     8'h07
`define GPC_PORT_MAX       3'h4

// ****************************************
// Timing
// ****************************************
`define GPC_DEBOUNCE_CYCLES 16

`endif

// file: common/gpc_pkg.sv
package gpc_pkg;

  typedef struct packed {
    logic reserved;
    logic debounce_en;
    logic polarity;
    logic level_type;
    logic lock;
    logic pullup_en;
    logic push_pull;
    logic out_en;
  } gpc_pin_cfg_s;

  typedef struct packed {
    logic pwake;
    logic system_mgmt_interrupt;
    logic irq;
  } gpc_route_s;

endpackage : gpc_pkg

// file: logic/gpc_gpio_cfg.sv
`timescale 1ns/10ps
`include "gpc_defines.svh"

// Operation
// - Activate reg 30h, gated by global bit 7
// - Base low bits 3-0 read zero
// - Interrupt type: only bit 1 writable, 03h
// - 74h and 75h read constant 04h
// - Select bits 6-4 pick port 0-4
// - Select bits 2-0 pick pin 0-7
// - Select resets 00h, bits 7,3 reserved
// - Window F1h reaches selected pin byte
// - Pin bytes reset 44h or 04h
// - Bit 6 enables input debounce
// - Bit 5 sets event polarity
// - Bit 4 selects edge or level
// - Ports 2,3 hold only bits 3-0
// - Routing register at F2h, read/write on ports 0,1,4
// - Lock freezes drive settings until reset
// - Bit 0 output enable, bit 1 type
// - Bit 2 enables internal pull-up
// - Routing bits forward to three requests
module gpc_gpio_cfg
  import gpc_pkg::*;
#(
  parameter int PINS            = 40,
  parameter int DEBOUNCE_CYCLES = `GPC_DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Register port
  input  wire logic [7:0]       addr_in,
  input  wire logic [7:0]       wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [7:0]       rdata_out,
  // Global configuration
  input  wire logic             global_config_one_en_in,
  // Pins
  input  wire logic [PINS-1:0]  pin_in,
  input  wire logic [PINS-1:0]  data_out_in,
  output logic      [PINS-1:0]  pin_out,
  output logic      [PINS-1:0]  pin_oe_n_out,
  output logic      [PINS-1:0]  pin_pullup_out,
  // Events
  output logic      [PINS-1:0]  event_out,
  output logic                  irq_req_out,
  output logic                  system_mgmt_interrupt_out,
  output logic                  power_wake_request_out
);

  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_evt_port(input logic [2:0] port);
    is_evt_port = (port == 3'h0) || (port == 3'h1) || (port == 3'h4);
  endfunction : is_evt_port

  function automatic logic [2:0] port_of(input int idx);
    port_of = 3'(idx / 8);
  endfunction : port_of

  // ****************************************
  // Configuration bank
  // ****************************************
  logic [7:0]   activate_r;
  logic [7:0]   base_hi_r;
  logic [7:0]   base_lo_r;
  logic [7:0]   irq_num_r;
  logic [7:0]   irq_type_r;
  logic [7:0]   pin_sel_r;
  gpc_pin_cfg_s cfg_r   [PINS];
  gpc_route_s   route_r [PINS];
  logic         unit_en;
  logic         sel_ok;
  logic         sel_evt;
  logic [5:0]   sel_idx;
  logic [7:0]   cfg_wr_nxt;

  assign unit_en = activate_r[0] & global_config_one_en_in;
  assign sel_ok  = pin_sel_r[6:4] <= `GPC_PORT_MAX;
  assign sel_evt = is_evt_port(pin_sel_r[6:4]);
  assign sel_idx = {pin_sel_r[6:4], pin_sel_r[2:0]};

  always_comb begin
    cfg_wr_nxt = wdata_in & (sel_evt ? `GPC_CFG_EVT_MASK : `GPC_CFG_PLAIN_MASK);
    if (sel_ok && cfg_r[sel_idx].lock) begin
      cfg_wr_nxt = (cfg_wr_nxt & ~`GPC_CFG_LOCKED_MASK)
                 | (cfg_r[sel_idx] & `GPC_CFG_LOCKED_MASK);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      activate_r <= `GPC_RST_ZERO;
      base_hi_r  <= `GPC_RST_ZERO;
      base_lo_r  <= `GPC_RST_ZERO;
      irq_num_r  <= `GPC_RST_ZERO;
      irq_type_r <= `GPC_RST_IRQ_TYPE;
      pin_sel_r  <= `GPC_RST_ZERO;
    end else if (wr_in) begin
      unique case (addr_in)
        `GPC_OFF_ACTIVATE: activate_r <= wdata_in;
        `GPC_OFF_BASE_HI:  base_hi_r  <= wdata_in;
        `GPC_OFF_BASE_LO:  base_lo_r  <= wdata_in & `GPC_BASE_LO_MASK;
        `GPC_OFF_IRQ_NUM:  irq_num_r  <= wdata_in;
        `GPC_OFF_IRQ_TYPE: begin
          irq_type_r <= (irq_type_r & ~`GPC_IRQ_TYPE_WMASK)
                      | (wdata_in & `GPC_IRQ_TYPE_WMASK);
        end
        `GPC_OFF_PIN_SEL:  pin_sel_r  <= wdata_in & `GPC_SEL_MASK;
        default: ;
      endcase
    end
  end

  // Per-pin setting bytes and routing
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < PINS; i++) begin
        cfg_r[i]   <= is_evt_port(port_of(i)) ? `GPC_RST_CFG_EVT
                                              : `GPC_RST_CFG_PLAIN;
        route_r[i] <= '0;
      end
    end else if (wr_in && sel_ok) begin
      if (addr_in == `GPC_OFF_PIN_CFG) begin
        cfg_r[sel_idx] <= cfg_wr_nxt;
      end
      if (addr_in == `GPC_OFF_ROUTE && sel_evt) begin
        route_r[sel_idx] <= 3'(wdata_in & `GPC_ROUTE_MASK);
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_out <= `GPC_RST_ZERO;
    end else if (rd_in) begin
      unique case (addr_in)
        `GPC_OFF_ACTIVATE: rdata_out <= activate_r;
        `GPC_OFF_BASE_HI:  rdata_out <= base_hi_r;
        `GPC_OFF_BASE_LO:  rdata_out <= base_lo_r;
        `GPC_OFF_IRQ_NUM:  rdata_out <= irq_num_r;
        `GPC_OFF_IRQ_TYPE: rdata_out <= irq_type_r;
        `GPC_OFF_DMA_0:    rdata_out <= `GPC_DMA_NONE;
        `GPC_OFF_DMA_1:    rdata_out <= `GPC_DMA_NONE;
        `GPC_OFF_PIN_SEL:  rdata_out <= pin_sel_r;
        `GPC_OFF_PIN_CFG:  rdata_out <= sel_ok ? cfg_r[sel_idx] : 8'h00;
        `GPC_OFF_ROUTE: begin
          rdata_out <= (sel_ok && sel_evt) ? {5'h00, route_r[sel_idx]} : 8'h00;
        end
        `GPC_OFF_CTRL:     rdata_out <= {7'h00, unit_en};
        default:           rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  logic [PINS-1:0] data_hold_r;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      data_hold_r <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (!cfg_r[i].lock) begin
          data_hold_r[i] <= data_out_in[i];
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pin_out        <= '0;
      pin_oe_n_out   <= '1;
      pin_pullup_out <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        pin_pullup_out[i] <= cfg_r[i].pullup_en;
        pin_out[i]        <= cfg_r[i].push_pull & data_hold_r[i];
        pin_oe_n_out[i]   <= !(cfg_r[i].out_en &&
                               (cfg_r[i].push_pull || !data_hold_r[i]));
      end
    end
  end

  // ****************************************
  // Debounce and event detection
  // ****************************************
  logic [CW-1:0]   stable_cnt_r [PINS];
  logic [PINS-1:0] filt_r;
  logic [PINS-1:0] prev_r;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < PINS; i++) begin
        stable_cnt_r[i] <= '0;
      end
      filt_r <= pin_in;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (!is_evt_port(port_of(i)) || pin_in[i] == filt_r[i]) begin
          stable_cnt_r[i] <= '0;
          filt_r[i]       <= pin_in[i];
        end else if (!cfg_r[i].debounce_en ||
                     stable_cnt_r[i] == CW'(DEBOUNCE_CYCLES - 1)) begin
          stable_cnt_r[i] <= '0;
          filt_r[i]       <= pin_in[i];
        end else begin
          stable_cnt_r[i] <= stable_cnt_r[i] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      prev_r    <= pin_in;
      event_out <= '0;
    end else begin
      prev_r <= filt_r;
      for (int i = 0; i < PINS; i++) begin
        event_out[i] <= unit_en && is_evt_port(port_of(i)) &&
                        (filt_r[i] == cfg_r[i].polarity) &&
                        (cfg_r[i].level_type || filt_r[i] != prev_r[i]);
      end
    end
  end

  // ****************************************
  // Request forwarding
  // ****************************************
  logic [PINS-1:0] to_irq;
  logic [PINS-1:0] to_smi;
  logic [PINS-1:0] to_wake;

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      to_irq[i]  = event_out[i] & route_r[i].irq;
      to_smi[i]  = event_out[i] & route_r[i].system_mgmt_interrupt;
      to_wake[i] = event_out[i] & route_r[i].pwake;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_req_out               <= 1'b0;
      system_mgmt_interrupt_out <= 1'b0;
      power_wake_request_out    <= 1'b0;
    end else begin
      irq_req_out               <= |to_irq;
      system_mgmt_interrupt_out <= |to_smi;
      power_wake_request_out    <= |to_wake;
    end
  end

endmodule : gpc_gpio_cfg

// file: tb/gpc_gpio_cfg_asserts.sv
`timescale 1ns/10ps
// ****************************************
// Port checker
// ****************************************
module gpc_gpio_cfg_asserts #(
  parameter int PINS = 40
) (
  input wire logic            clk_in,
  input wire logic            resetn_in,
  input wire logic [7:0]      addr_in,
  input wire logic            rd_in,
  input wire logic [7:0]      rdata_out,
  input wire logic            global_config_one_en_in,
  input wire logic [PINS-1:0] event_out,
  input wire logic            irq_req_out,
  input wire logic            system_mgmt_interrupt_out,
  input wire logic            power_wake_request_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
  dma_fixed_a: assert property (rd_in && addr_in[7:1] == 7'h3a |=> rdata_out == 8'h04)
    else $error("dma report not 04");
  base_align_a: assert property (rd_in && addr_in == 8'h61 |=> rdata_out[3:0] == 4'h0)
    else $error("base low bits not zero");
  irq_type_a: assert property (rd_in && addr_in == 8'h71 |=> (rdata_out & 8'hfd) == 8'h01)
    else $error("interrupt type fixed bits wrong");
  sel_rsv_a: assert property (rd_in && addr_in == 8'hf0 |=> (rdata_out & 8'h88) == 8'h00)
    else $error("select reserved bits set");
  req_cause_a: assert property (irq_req_out || system_mgmt_interrupt_out ||
    power_wake_request_out |-> $past(|event_out))
    else $error("request without event");
  unit_off_a: assert property (!global_config_one_en_in [*3] |-> event_out == '0)
    else $error("event while unit disabled");
  plain_ports_a: assert property (event_out[31:16] == 16'h0000)
    else $error("event on port without detection");
endmodule : gpc_gpio_cfg_asserts

bind gpc_gpio_cfg gpc_gpio_cfg_asserts #(.PINS(PINS)) u_gpc_gpio_cfg_asserts (
  .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .global_config_one_en_in(global_config_one_en_in),
  .event_out(event_out), .irq_req_out(irq_req_out),
  .system_mgmt_interrupt_out(system_mgmt_interrupt_out),
  .power_wake_request_out(power_wake_request_out));

// file: tb/gpc_pin_partner.sv
`timescale 1ns/10ps
// ****************************************
// Devices on the pins
// ****************************************
module gpc_pin_partner #(
  parameter int PINS = 40
) (
  input  wire logic            clk_in,
  input  wire logic [PINS-1:0] ext_en_in,
  input  wire logic [PINS-1:0] ext_val_in,
  input  wire logic [PINS-1:0] pin_drv_in,
  input  wire logic [PINS-1:0] pin_oe_n_in,
  input  wire logic [PINS-1:0] pin_pullup_in,
  output logic      [PINS-1:0] pin_lvl_out
);
  logic [PINS-1:0] float_r = '0;
  // Released, unpulled pins wander
  always_ff @(posedge clk_in) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (!pin_oe_n_in[i]) begin
        pin_lvl_out[i] = pin_drv_in[i];
      end else if (ext_en_in[i]) begin
        pin_lvl_out[i] = ext_val_in[i];
      end else begin
        pin_lvl_out[i] = pin_pullup_in[i] | float_r[i];
      end
    end
  end
endmodule : gpc_pin_partner

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clk_in = 1'b0;
  logic        resetn_in, wr_in, rd_in, glob;
  logic [7:0]  addr_in, wdata_in, rdata_out;
  logic [39:0] pin_in, data_out_in, pin_out, pin_oe_n_out, pin_pullup_out, event_out;
  logic [39:0] ext_en, ext_val;
  logic        irq_req_out, system_mgmt_interrupt_out, power_wake_request_out;
  int          num_errors = 0, checked = 0, cycles = 0;

  gpc_gpio_cfg #(.PINS(40), .DEBOUNCE_CYCLES(4)) u_gpc_gpio_cfg (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .global_config_one_en_in(glob),
    .pin_in(pin_in), .data_out_in(data_out_in), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n_out), .pin_pullup_out(pin_pullup_out), .event_out(event_out),
    .irq_req_out(irq_req_out), .system_mgmt_interrupt_out(system_mgmt_interrupt_out),
    .power_wake_request_out(power_wake_request_out));
  gpc_pin_partner #(.PINS(40)) u_gpc_pin_partner (
    .clk_in(clk_in), .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_drv_in(pin_out),
    .pin_oe_n_in(pin_oe_n_out), .pin_pullup_in(pin_pullup_out), .pin_lvl_out(pin_in));

  always #10 clk_in = ~clk_in;

  // ****************************************
  // Bus cycles and checks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
    @(posedge clk_in);
  endtask : rd
  task automatic po(input int i, input logic [2:0] exp);
    repeat (3) @(posedge clk_in);
    #1;
    chk({5'h0, pin_oe_n_out[i], pin_out[i], pin_pullup_out[i]}, {5'h0, exp});
    @(posedge clk_in);
  endtask : po
  task automatic ev(input logic [7:0] n_exp, input logic [7:0] q_exp);
    logic [7:0] n, q;
    n = 8'h00;
    q = 8'h00;
    repeat (12) begin
      @(posedge clk_in);
      #1;
      n += event_out[0];
      q += {power_wake_request_out, system_mgmt_interrupt_out, irq_req_out};
    end
    chk(n, n_exp);
    chk(q, q_exp);
    @(posedge clk_in);
  endtask : ev

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rd(8'h30, 8'h00);
    wr(8'h60, 8'ha5);
    rd(8'h60, 8'ha5);
    wr(8'h70, 8'h5a);
    rd(8'h70, 8'h5a);
    rd(8'hf8, 8'h00);
    wr(8'h61, 8'hff);
    rd(8'h61, 8'hf0);
    rd(8'h71, 8'h03);
    wr(8'h71, 8'h00);
    rd(8'h71, 8'h01);
    wr(8'h74, 8'hff);
    rd(8'h74, 8'h04);
    rd(8'h75, 8'h04);
    rd(8'h20, 8'h00);
    rd(8'hf0, 8'h00);
    wr(8'hf0, 8'hff);
    rd(8'hf0, 8'h77);
    rd(8'hf1, 8'h00);
  endtask : t_regs
  task automatic t_window();
    wr(8'hf0, 8'h23);
    rd(8'hf1, 8'h04);
    wr(8'hf1, 8'h7f);
    rd(8'hf1, 8'h0f);
    wr(8'hf2, 8'hff);
    rd(8'hf2, 8'h00);
    wr(8'hf0, 8'h47);
    rd(8'hf1, 8'h44);
    wr(8'hf1, 8'h54);
    rd(8'hf1, 8'h54);
    wr(8'hf2, 8'hff);
    rd(8'hf2, 8'h07);
    wr(8'hf0, 8'h46);
    rd(8'hf1, 8'h44);
    rd(8'hf2, 8'h00);
  endtask : t_window
  task automatic t_pins();
    wr(8'hf0, 8'h12);
    wr(8'hf1, 8'h07);
    po(10, 3'b011);
    wr(8'hf1, 8'h0b);
    po(10, 3'b010);
    data_out_in[10] <= 1'b0;
    wr(8'hf1, 8'h04);
    rd(8'hf1, 8'h0b);
    po(10, 3'b010);
    wr(8'hf0, 8'h13);
    wr(8'hf1, 8'h05);
    po(11, 3'b101);
    data_out_in[11] <= 1'b0;
    po(11, 3'b001);
  endtask : t_pins
  task automatic t_event();
    wr(8'h30, 8'h01);
    rd(8'h30, 8'h01);
    rd(8'hf8, 8'h01);
    wr(8'hf0, 8'h00);
    wr(8'hf2, 8'h07);
    wr(8'hf1, 8'h24);
    ext_val[0] <= 1'b1;
    ev(8'h01, 8'h07);
    ext_val[0] <= 1'b0;
    ev(8'h00, 8'h00);
    wr(8'hf1, 8'h04);
    ext_val[0] <= 1'b1;
    ev(8'h00, 8'h00);
    ext_val[0] <= 1'b0;
    ev(8'h01, 8'h07);
    wr(8'hf1, 8'h34);
    ext_val[0] <= 1'b1;
    ev(8'h0b, 8'h46);
    ext_val[0] <= 1'b0;
    ev(8'h01, 8'h0e);
    wr(8'hf1, 8'h64);
    ext_val[0] <= 1'b1;
    repeat (2) @(posedge clk_in);
    ext_val[0] <= 1'b0;
    ev(8'h00, 8'h00);
    ext_val[0] <= 1'b1;
    ev(8'h01, 8'h07);
    wr(8'hf1, 8'h24);
    glob <= 1'b0;
    ext_val[0] <= 1'b0;
    ev(8'h00, 8'h00);
    ext_val[0] <= 1'b1;
    ev(8'h00, 8'h00);
    glob <= 1'b1;
    wr(8'hf2, 8'h02);
    ext_val[0] <= 1'b0;
    ev(8'h00, 8'h00);
    ext_val[0] <= 1'b1;
    ev(8'h01, 8'h02);
  endtask : t_event

  task automatic finish_test();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    resetn_in = 1'b0;
    {wr_in, rd_in, addr_in, wdata_in} = '0;
    glob = 1'b1;
    data_out_in = '1;
    ext_en = 40'h1;
    ext_val = '0;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_window();
    t_pins();
    t_event();
    finish_test();
  end
endmodule : tb
